//--- iqp_cfg.svh
/*
 * Constants of the interrupt status and priority block: register byte
 * offsets, field positions, reset values and status bit classes.
 * Assumes it is included by bare name and may be included more than once.
 */
`ifndef IQP_CFG_SVH
`define IQP_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IQP_OFF_STATUS2    16'he214
`define IQP_OFF_WAN_PRIO   16'he218
`define IQP_OFF_BE_PRIO    16'he21c
`define IQP_OFF_LAN_PRIO   16'he220
`define IQP_OFF_USB_PRIO   16'he224
`define IQP_OFF_ENABLE2    16'he280
`define IQP_OFF_EXT_MODE   16'he284
`define IQP_OFF_FIQ_SEL2   16'he288
`define IQP_OFF_ARB        16'he28c

// ----------------------------------------------------------------------
// Field widths, positions and reset values
// ----------------------------------------------------------------------
`define IQP_ST_W           26
`define IQP_LVL_W          4
`define IQP_NSRC           18
`define IQP_ID_W           5
`define IQP_WAN_W          28
`define IQP_USB_W          12
`define IQP_ST_RESET       26'h0000000
`define IQP_WAN_RESET      28'h0000000
`define IQP_USB_RESET      12'h000
`define IQP_LVL_RESET      4'h0
`define IQP_EXT_LSB        2
`define IQP_EXT_MASK       26'h000003c
// Bits latched on a rising source edge and cleared by writing one
`define IQP_EDGE_MASK      26'h0923fc0
`define IQP_BIT_U1_TXE     13
`define IQP_BIT_U1_RX      14
`define IQP_BIT_U1_LINE    15
`define IQP_BIT_U1_MODEM   16
`define IQP_BIT_UART2      17
`define IQP_BIT_PERIPH     8
`define IQP_BIT_TIMER      6

`endif

//--- iqp_core.sv
/*
 * Interrupt status register two, per-source priority registers and
 * request generation, as an APB slave with one wait-free access phase.
 * Assumes peripheral sources share i_clock; external pins are async.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "iqp_cfg.svh"

module iqp_core #(
    parameter int ADDR_W = 16
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_resetn,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ADDR_W-1:0]    i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire iqp_pkg::iqp_src_t    i_src,
    input  wire logic [3:0]           i_ext_pin,
    input  wire logic [`IQP_NSRC-1:0] i_prio_req,
    input  wire logic                 i_fiq_req,
    output logic                      o_irq,
    output logic                      o_fiq,
    output logic                      o_irq_valid,
    output logic [`IQP_LVL_W-1:0]     o_irq_level,
    output logic [`IQP_ID_W-1:0]      o_irq_id
);

    // ------------------------------------------------------------------
    // Priority arbitration
    // ------------------------------------------------------------------
    // Strict compare keeps the lowest index on equal levels
    function automatic iqp_pkg::iqp_arb_t pick(
        input logic [`IQP_NSRC-1:0]            req,
        input logic [`IQP_NSRC*`IQP_LVL_W-1:0] lvl
    );
        iqp_pkg::iqp_arb_t r;
        r = '0;
        for (int i = 0; i < `IQP_NSRC; i++) begin
            if (req[i] && (!r.valid || lvl[i*4 +: 4] > r.level)) begin
                r.valid = 1'b1;
                r.level = lvl[i*4 +: 4];
                r.id    = 5'(i);
            end
        end
        return r;
    endfunction : pick

    // ------------------------------------------------------------------
    // State and derived signals
    // ------------------------------------------------------------------
    iqp_pkg::iqp_state_t          st_q;
    iqp_pkg::iqp_state_t          st_d;
    logic [`IQP_ST_W-1:0]         level_vec;
    logic [`IQP_ST_W-1:0]         edge_mask;
    logic [`IQP_ST_W-1:0]         set_ev;
    logic [`IQP_ST_W-1:0]         w1c;
    logic [`IQP_ST_W-1:0]         status_rd;
    logic [`IQP_ST_W-1:0]         pend;
    logic [`IQP_NSRC*4-1:0]       lvl_all;
    logic                         setup;
    logic                         access;
    logic                         wr;

    // Bus phases; pready only rises for the cycle after a setup
    assign setup  = i_psel & ~i_penable;
    assign access = i_psel & i_penable & st_q.pready;
    assign wr     = access & i_pwrite;

    // Level-driven bits follow their sources directly; external pin bits follow the synchroniser output
    always_comb begin
        level_vec = '0;
        level_vec[`IQP_BIT_U1_MODEM] = |i_src.modem_delta;
        level_vec[`IQP_BIT_U1_LINE]  = |i_src.u1_line_err;
        level_vec[`IQP_BIT_U1_RX]    = i_src.u1_rx_avail
                                     | i_src.u1_char_timeout;
        for (int u = 0; u < 3; u++) begin
            level_vec[`IQP_BIT_UART2 + 3*u + 1] = i_src.rx_trig[u];
            level_vec[`IQP_BIT_UART2 + 3*u + 2] = i_src.line_err[u];
        end
        level_vec[5:2] = st_q.ext_s2;
        level_vec[1]   = i_src.comms_tx_empty;
        level_vec[0]   = i_src.comms_rx_full;
    end

    // Rising-edge events that set sticky bits
    always_comb begin
        set_ev = '0;
        set_ev[`IQP_BIT_U1_TXE] = i_src.thr_empty[0] & ~st_q.thr_prev[0];
        for (int u = 0; u < 3; u++) begin
            set_ev[`IQP_BIT_UART2 + 3*u] =
                i_src.thr_empty[u+1] & ~st_q.thr_prev[u+1];
        end
        set_ev[12:8] = i_src.periph_evt & ~st_q.periph_prev;
        set_ev[7:6]  = i_src.timer_evt & ~st_q.timer_prev;
        set_ev[5:2]  = st_q.ext_s2 & ~st_q.ext_prev & st_q.ext_edge;
    end

    // Edge-mode external bits join the fixed edge class
    assign edge_mask = `IQP_EDGE_MASK
                     | ({22'h000000, st_q.ext_edge} << `IQP_EXT_LSB);
    assign status_rd = (st_q.sticky & edge_mask) | (level_vec & ~edge_mask);
    assign w1c       = (wr && i_paddr == `IQP_OFF_STATUS2) ?
                       i_pwdata[`IQP_ST_W-1:0] : '0;
    assign pend      = status_rd & st_q.enable;
    assign lvl_all   = {st_q.usb_prio, st_q.lan_prio, st_q.be_prio, st_q.wan_prio};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Pin synchroniser; the first stage feeds only the second
        st_d.ext_s1      = i_ext_pin;
        st_d.ext_s2      = st_q.ext_s1;
        st_d.ext_prev    = st_q.ext_s2;
        st_d.thr_prev    = i_src.thr_empty;
        st_d.periph_prev = i_src.periph_evt;
        st_d.timer_prev  = i_src.timer_evt;
        // Set wins over a same-cycle write-one clear; reads never clear
        st_d.sticky = ((st_q.sticky & ~(w1c & edge_mask)) | set_ev)
                    & edge_mask;
        if (wr) begin
            case (i_paddr)
                `IQP_OFF_WAN_PRIO: st_d.wan_prio = i_pwdata[27:0];
                `IQP_OFF_BE_PRIO:  st_d.be_prio  = i_pwdata[3:0];
                `IQP_OFF_LAN_PRIO: st_d.lan_prio = i_pwdata[27:0];
                `IQP_OFF_USB_PRIO: st_d.usb_prio = i_pwdata[11:0];
                `IQP_OFF_ENABLE2:  st_d.enable   = i_pwdata[`IQP_ST_W-1:0];
                `IQP_OFF_EXT_MODE: st_d.ext_edge = i_pwdata[3:0];
                `IQP_OFF_FIQ_SEL2: st_d.fiq_sel  = i_pwdata[`IQP_ST_W-1:0];
                default: ;
            endcase
        end
        // Answer one cycle after setup; data sampled at setup
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        st_d.prdata  = '0;
        if (setup) begin
            case (i_paddr)
                `IQP_OFF_STATUS2:  st_d.prdata = {6'h00, status_rd};
                `IQP_OFF_WAN_PRIO: st_d.prdata = {4'h0, st_q.wan_prio};
                `IQP_OFF_BE_PRIO:  st_d.prdata = {28'h0000000, st_q.be_prio};
                `IQP_OFF_LAN_PRIO: st_d.prdata = {4'h0, st_q.lan_prio};
                `IQP_OFF_USB_PRIO: st_d.prdata = {20'h00000, st_q.usb_prio};
                `IQP_OFF_ENABLE2:  st_d.prdata = {6'h00, st_q.enable};
                `IQP_OFF_EXT_MODE: st_d.prdata = {28'h0000000, st_q.ext_edge};
                `IQP_OFF_FIQ_SEL2: st_d.prdata = {6'h00, st_q.fiq_sel};
                `IQP_OFF_ARB:      st_d.prdata = {22'h000000, st_q.arb};
                default:           st_d.pslverr = 1'b1;
            endcase
        end
        // Fast request masks the normal one outright
        st_d.fast_interrupt_request = (|(pend & st_q.fiq_sel)) | i_fiq_req;
        st_d.irq = ~st_d.fast_interrupt_request & ((|(pend & ~st_q.fiq_sel)) | (|i_prio_req));
        st_d.arb = pick(i_prio_req, lvl_all);
    end

    // Register the whole state
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q          <= '0;
            st_q.wan_prio <= `IQP_WAN_RESET;
            st_q.lan_prio <= `IQP_WAN_RESET;
            st_q.be_prio  <= `IQP_LVL_RESET;
            st_q.usb_prio <= `IQP_USB_RESET;
            st_q.sticky   <= `IQP_ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_prdata    = st_q.prdata;
    assign o_pready    = st_q.pready;
    assign o_pslverr   = st_q.pslverr;
    assign o_irq       = st_q.irq;
    assign o_fiq       = st_q.fast_interrupt_request;
    assign o_irq_valid = st_q.arb.valid;
    assign o_irq_level = st_q.arb.level;
    assign o_irq_id    = st_q.arb.id;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_rd_setup(logic [15:0] a);
        i_psel && !i_penable && !i_pwrite && i_paddr == a;
    endsequence

    sequence s_wr_done(logic [15:0] a);
        i_psel && i_penable && st_q.pready && i_pwrite && i_paddr == a;
    endsequence

    a_modem_or_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_STATUS2) |=> o_prdata[16] == $past(|i_src.modem_delta))
        else $error("modem status bit wrong");

    a_line_err_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_STATUS2) |=> o_prdata[15] == $past(|i_src.u1_line_err))
        else $error("line error status bit wrong");

    a_rx_cause_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_STATUS2) |=>
            o_prdata[14] == ($past(i_src.u1_rx_avail) || $past(i_src.u1_char_timeout)))
        else $error("receive status bit wrong");

    a_txe_edge_set: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(i_src.thr_empty[0]) |=> st_q.sticky[13])
        else $error("transmit empty edge not latched");

    a_timer_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_q.sticky[7] && !(wr && i_paddr == `IQP_OFF_STATUS2 && i_pwdata[7])
            |=> st_q.sticky[7])
        else $error("timer status lost without clear");

    a_ext_level_pin: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (!st_q.ext_edge[0] && i_ext_pin[0]) [*3] |-> status_rd[2])
        else $error("level external status not following pin");

    // Masters idle one edge between transfers, so the read setup lands two cycles on
    a_prio_wr_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_wr_done(`IQP_OFF_WAN_PRIO) ##2 s_rd_setup(`IQP_OFF_WAN_PRIO)
            |=> o_prdata == {4'h0, $past(i_pwdata[27:0], 3)})
        else $error("priority readback mismatch");

    a_lan_wr_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_wr_done(`IQP_OFF_LAN_PRIO) ##2 s_rd_setup(`IQP_OFF_LAN_PRIO)
            |=> o_prdata == {4'h0, $past(i_pwdata[27:0], 3)})
        else $error("lan priority readback mismatch");

    a_usb_reserved: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_USB_PRIO) |=> o_prdata[31:12] == 20'h00000)
        else $error("reserved usb bits not zero");

    a_fiq_over_irq: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_fiq |-> !o_irq)
        else $error("normal request alongside fast request");

    a_be_reserved: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_BE_PRIO) |=> o_prdata[31:4] == 28'h0000000)
        else $error("reserved bus error bits not zero");

    a_read_keeps: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_q.sticky[6] && !wr |=> st_q.sticky[6])
        else $error("status bit cleared by read");

    a_irq_gated: assert property (@(posedge i_clock) disable iff (!i_resetn)
        pend == '0 && i_prio_req == '0 |=> !o_irq)
        else $error("request without enabled source");

    a_arb_single: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $onehot(i_prio_req) |=> o_irq_valid
            && o_irq_id == 5'($clog2($past(i_prio_req))))
        else $error("single request not chosen");

    a_comms_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_STATUS2) |=> o_prdata[1:0]
            == $past({i_src.comms_tx_empty, i_src.comms_rx_full}))
        else $error("comms status bits wrong");

    a_uart4_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_rd_setup(`IQP_OFF_STATUS2) |=> o_prdata[25:24]
            == $past({i_src.line_err[2], i_src.rx_trig[2]}))
        else $error("uart4 level status bits wrong");

    a_periph_edge: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(i_src.periph_evt[4]) |=> st_q.sticky[12])
        else $error("management serial edge not latched");

    a_timer_edge: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(i_src.timer_evt[0]) |=> st_q.sticky[6])
        else $error("timer edge not latched");

    // A steady-high source must not re-set the bit once written off
    a_txe_w1c: assert property (@(posedge i_clock) disable iff (!i_resetn)
        wr && i_paddr == `IQP_OFF_STATUS2 && i_pwdata[13] && !set_ev[13]
            |=> !st_q.sticky[13])
        else $error("transmit empty not cleared by write of one");

    a_ext_edge_w1c: assert property (@(posedge i_clock) disable iff (!i_resetn)
        st_q.ext_edge[1] && wr && i_paddr == `IQP_OFF_STATUS2 && i_pwdata[3]
            && !set_ev[3] |=> !st_q.sticky[3])
        else $error("edge external status not cleared");

    a_fiq_follows: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_fiq_req |=> o_fiq)
        else $error("fast request not passed on");

    a_irq_enabled: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (|(pend & ~st_q.fiq_sel)) && !(|(pend & st_q.fiq_sel)) && !i_fiq_req
            |=> o_irq)
        else $error("enabled source gave no request");

    // Ready answers every setup for exactly one cycle
    a_ready_pulse: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("ready not a single-cycle answer");

endmodule : iqp_core

//--- iqp_host_model.sv
/*
 * Processor-side model: raises the fast request on command and counts
 * the rising edges of the normal and fast requests that it receives.
 * Assumes one clock shared with the block and its active-low reset.
 */
`timescale 1ns/100ps

module iqp_host_model (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_irq,
    input  wire logic i_fiq,
    input  wire logic i_raise_fiq,
    output logic      o_fiq_req,
    output int        o_irq_rises,
    output int        o_fiq_rises
);
    logic irq_q;
    logic fiq_q;

    // --------------------------------------------------------------
    // Request launch and edge counting
    // --------------------------------------------------------------
    // Launched just after an edge, so the block sees a clean level
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fiq_req   <= 1'b0;
            irq_q       <= 1'b0;
            fiq_q       <= 1'b0;
            o_irq_rises <= 0;
            o_fiq_rises <= 0;
        end else begin
            o_fiq_req   <= i_raise_fiq;
            irq_q       <= i_irq;
            fiq_q       <= i_fiq;
            o_irq_rises <= o_irq_rises + int'(i_irq & ~irq_q);
            o_fiq_rises <= o_fiq_rises + int'(i_fiq & ~fiq_q);
        end
    end
endmodule : iqp_host_model

//--- iqp_pkg.sv
/*
 * Types of the interrupt status and priority block.
 * Assumes iqp_cfg.svh is on the include path.
 */
`include "iqp_cfg.svh"

package iqp_pkg;

    // Source conditions from peripherals on the system clock
    typedef struct packed {
        logic [3:0] modem_delta;
        logic [3:0] u1_line_err;
        logic       u1_rx_avail;
        logic       u1_char_timeout;
        logic [3:0] thr_empty;
        logic [2:0] rx_trig;
        logic [2:0] line_err;
        logic [4:0] periph_evt;
        logic [1:0] timer_evt;
        logic       comms_tx_empty;
        logic       comms_rx_full;
    } iqp_src_t;

    // Arbitration result
    typedef struct packed {
        logic                  valid;
        logic [`IQP_LVL_W-1:0] level;
        logic [`IQP_ID_W-1:0]  id;
    } iqp_arb_t;

    // Whole state of the block
    typedef struct packed {
        logic [`IQP_ST_W-1:0]  sticky;
        logic [`IQP_ST_W-1:0]  enable;
        logic [`IQP_ST_W-1:0]  fiq_sel;
        logic [3:0]            ext_edge;
        logic [3:0]            ext_s1;
        logic [3:0]            ext_s2;
        logic [3:0]            ext_prev;
        logic [3:0]            thr_prev;
        logic [4:0]            periph_prev;
        logic [1:0]            timer_prev;
        logic [`IQP_WAN_W-1:0] wan_prio;
        logic [`IQP_LVL_W-1:0] be_prio;
        logic [`IQP_WAN_W-1:0] lan_prio;
        logic [`IQP_USB_W-1:0] usb_prio;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  irq;
        logic                  fast_interrupt_request;
        iqp_arb_t              arb;
    } iqp_state_t;

endpackage : iqp_pkg

//--- test_irq_status_and_priority.sv
/*
 * Self-checking bench of the interrupt status and priority block.
 * Assumes iqp_pkg, iqp_core and iqp_host_model are compiled before it.
 */
`timescale 1ns/100ps
`include "iqp_cfg.svh"

module test_irq_status_and_priority;
    typedef struct packed {
        logic [15:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } iqp_row_t;
    localparam logic [15:0] ST = `IQP_OFF_STATUS2;

    logic              i_clock = 1'b0;
    logic              i_resetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [15:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    iqp_pkg::iqp_src_t src;
    logic [3:0]        ext_pin;
    logic [17:0]       prio_req;
    logic              fiq_req;
    logic              irq;
    logic              fast_interrupt_request;
    logic              avalid;
    logic [3:0]        alevel;
    logic [4:0]        aid;
    logic              raise_fiq;
    int                irq_rises;
    int                fiq_rises;
    int                bad_count = 0;
    int                num_checks = 0;
    int                cyc = 0;
    logic [31:0]       rd;
    logic              err;
    // Masked widths: upper nibbles of the MAC registers read zero
    iqp_row_t rows [9] = '{
        '{`IQP_OFF_WAN_PRIO, 32'hffffffff, 32'h0fffffff, 1'b0},
        '{`IQP_OFF_WAN_PRIO, 32'h07654321, 32'h07654321, 1'b0},
        '{`IQP_OFF_BE_PRIO,  32'hffffffff, 32'h0000000f, 1'b0},
        '{`IQP_OFF_BE_PRIO,  32'h0000000a, 32'h0000000a, 1'b0},
        '{`IQP_OFF_LAN_PRIO, 32'hffffffff, 32'h0fffffff, 1'b0},
        '{`IQP_OFF_LAN_PRIO, 32'h01234567, 32'h01234567, 1'b0},
        '{`IQP_OFF_USB_PRIO, 32'hffffffff, 32'h00000fff, 1'b0},
        '{ST,                32'hffffffff, 32'h00000000, 1'b0},
        '{16'he2f0,          32'hffffffff, 32'h00000000, 1'b1}
    };
    // Request pattern, then expected valid, level and index
    logic [27:0] arbs [5] = '{
        {18'h00005, 1'b1, 4'h5, 5'd0},
        {18'h00081, 1'b1, 4'h5, 5'd0},
        {18'h00084, 1'b1, 4'h5, 5'd7},
        {18'h10004, 1'b1, 4'hf, 5'd16},
        {18'h00002, 1'b1, 4'h0, 5'd1}
    };

    iqp_core #(.ADDR_W(16)) dut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_src(src), .i_ext_pin(ext_pin),
        .i_prio_req(prio_req), .i_fiq_req(fiq_req), .o_irq(irq), .o_fiq(fast_interrupt_request),
        .o_irq_valid(avalid), .o_irq_level(alevel), .o_irq_id(aid));
    iqp_host_model host (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_irq(irq), .i_fiq(fast_interrupt_request),
        .i_raise_fiq(raise_fiq), .o_fiq_req(fiq_req), .o_irq_rises(irq_rises),
        .o_fiq_rises(fiq_rises));

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    always #50 i_clock = ~i_clock;

    // A hung handshake ends here rather than running forever
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask : tick

    // One transfer; an idle edge first keeps strobes from double assignment
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees ready
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask : rchk

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {i_resetn, psel, penable, pwrite, raise_fiq} = 5'h00;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        src = '0;
        ext_pin = 4'h0;
        prio_req = 18'h00000;
        tick(16);
        i_resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rchk("reset value", ST + 16'(4 * i), 32'h00000000);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            apb(1'b0, rows[i].a, 32'h00000000);
            chk("reg data", rows[i].exp, rd);
            chk("reg error", {31'h0, rows[i].err}, {31'h0, err});
        end
        $display("test registers done");
        // Level sources follow their cause and ignore writes of one
        src.modem_delta <= 4'h8;
        src.u1_line_err <= 4'h1;
        src.u1_rx_avail <= 1'b1;
        src.rx_trig <= 3'h7;
        src.line_err <= 3'h7;
        src.comms_tx_empty <= 1'b1;
        src.comms_rx_full <= 1'b1;
        tick(2);
        rchk("level set", ST, 32'h036dc003);
        wr(ST, 32'hffffffff);
        rchk("level kept", ST, 32'h036dc003);
        src <= '0;
        tick(2);
        rchk("level drop", ST, 32'h00000000);
        src.u1_char_timeout <= 1'b1;
        tick(2);
        rchk("timeout", ST, 32'h00004000);
        src.u1_char_timeout <= 1'b0;
        tick(2);
        rchk("timeout drop", ST, 32'h00000000);
        $display("test level status done");
        // Edge sources stay high: a write of one must still clear them
        src.thr_empty <= 4'hf;
        src.periph_evt <= 5'h1f;
        src.timer_evt <= 2'h3;
        tick(3);
        rchk("edge set", ST, 32'h00923fc0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`IQP_OFF_ENABLE2, 32'h00000080);
        tick(2);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(`IQP_OFF_FIQ_SEL2, 32'h00000080);
        tick(2);
        chk("fiq routed", 32'h2, {30'h0, fast_interrupt_request, irq});
        chk("irq count", 32'h1, 32'(irq_rises));
        wr(`IQP_OFF_FIQ_SEL2, 32'h00000000);
        raise_fiq <= 1'b1;
        tick(3);
        chk("fiq request", 32'h2, {30'h0, fast_interrupt_request, irq});
        raise_fiq <= 1'b0;
        tick(3);
        chk("fiq count", 32'h2, 32'(fiq_rises));
        wr(ST, 32'h00002000);
        rchk("one cleared", ST, 32'h00921fc0);
        wr(ST, 32'hffffffff);
        rchk("all cleared", ST, 32'h00000000);
        src <= '0;
        $display("test edge status done");
        // External pins: level mode first, then edge mode
        ext_pin <= 4'ha;
        tick(6);
        wr(ST, 32'h0000003c);
        rchk("ext level", ST, 32'h00000028);
        ext_pin <= 4'h0;
        tick(6);
        rchk("ext low", ST, 32'h00000000);
        wr(`IQP_OFF_EXT_MODE, 32'h0000000f);
        ext_pin <= 4'ha;
        tick(1);
        ext_pin <= 4'h0;
        tick(6);
        rchk("ext edge", ST, 32'h00000028);
        wr(ST, 32'h00000008);
        rchk("ext w1", ST, 32'h00000020);
        $display("test external done");
        // Arbitration: highest level wins, lowest index breaks ties
        wr(`IQP_OFF_WAN_PRIO, 32'h00000305);
        wr(`IQP_OFF_BE_PRIO, 32'h00000005);
        wr(`IQP_OFF_USB_PRIO, 32'h000000f0);
        foreach (arbs[i]) begin
            prio_req <= arbs[i][27:10];
            tick(3);
            chk("arbitration", {22'h0, arbs[i][9:0]}, {22'h0, avalid, alevel, aid});
        end
        $display("test arbitration done");
        // Reset in mid-run must drop programmed levels and requests
        prio_req <= 18'h00000;
        i_resetn <= 1'b0;
        tick(2);
        i_resetn <= 1'b1;
        rchk("wan reset", `IQP_OFF_WAN_PRIO, 32'h00000000);
        rchk("usb reset", `IQP_OFF_USB_PRIO, 32'h00000000);
        chk("req reset", 32'h0, {30'h0, fast_interrupt_request, irq});
        chk("arb reset", 32'h0, {22'h0, avalid, alevel, aid});
        $display("test second reset done");
        end_sim();
    end
endmodule : test_irq_status_and_priority
